// File: core/esn_cfg.svh
// constants of the event status notifier: rom keys, sense values, field values
// assumes inclusion by core/esn_notifier.sv; core/esn_pkg.sv does not include it
`ifndef ESN_CFG_SVH
`define ESN_CFG_SVH
`define ESN_KEY_CMD_SET 8'h3A
`define ESN_KEY_CMD_REV 8'h3B
`define ESN_KEY_LUN 8'h14
`define ESN_DEV_TYPE_DISK 8'h00
`define ESN_LUN_SINGLE 16'h0000
`define ESN_VPD_SERIAL_PAGE 8'h80
`define ESN_STAT_CHECK 8'h02
`define ESN_SK_NOT_READY 8'h02
`define ESN_SK_UNIT_ATTN 8'h06
`define ESN_SC_NOT_READY 8'h04
`define ESN_SC_MEDIUM_CHG 8'h28
`define ESN_SC_RESET 8'h29
`define ESN_SC_EVENT 8'h7F
`define ESN_SQ_POWER 8'h02
`define ESN_SQ_MEDIA 8'h04
`define ESN_SQ_BUSY 8'h06
`define ESN_SQ_NONE 8'h00
`define ESN_RESERVED_BYTE 8'h00
`define ESN_ROM_WORDS 3
`endif

// File: core/esn_pkg.sv
// types of the event status notifier
// assumes core/esn_cfg.svh holds the numbers
`default_nettype none
package esn_pkg;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] senseKey;
    logic [7:0] senseCode;
    logic [7:0] senseQual;
    logic [31:0] info;
    logic [47:0] fifoAddr;
  } esn_block_t;
  typedef struct packed {
    logic [7:0] evCode;
    logic [7:0] evStatus;
    logic [15:0] evSpecific;
  } esn_event_t;
  typedef enum logic [1:0] {
    ESN_IDLE = 2'b00,
    ESN_SEND = 2'b01,
    ESN_WAIT = 2'b11
  } esn_state_t;
endpackage : esn_pkg
`default_nettype wire

// File: core/esn_notifier.sv
// event status notifier: config rom unit directory entries and unsolicited status blocks
// assumes one clock, the link layer takes a block when blkValid and blkReady are both high
// assumes event inputs are single-cycle pulses on clk_sys; devReady and busReset may be asynchronous
// no software registers: rom words are chosen by romIdx and show one cycle later
`include "esn_cfg.svh"
`default_nettype none
module esn_notifier #(
  parameter logic [7:0] CMD_SET_SPEC = 8'h00,
  parameter logic [23:0] CMD_SET = 24'h000000,
  parameter logic [23:0] CMD_SET_REV = 24'h000000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] romIdx,
  output logic [31:0] romWord,
  input wire logic statusEnableWrite,
  input wire logic loginValid,
  input wire logic [47:0] loginFifoAddr,
  input wire logic devReady,
  input wire logic busReset,
  input wire logic powerEvValid,
  input wire esn_pkg::esn_event_t powerEv,
  input wire logic mediaEvValid,
  input wire esn_pkg::esn_event_t mediaEv,
  input wire logic busyEvValid,
  input wire esn_pkg::esn_event_t busyEv,
  input wire logic deferredValid,
  input wire esn_pkg::esn_block_t deferredBlk,
  input wire logic securityLocked,
  output logic mediaAccessOk,
  output logic [7:0] serialVpdPage,
  output logic blkValid,
  output esn_pkg::esn_block_t blkOut,
  input wire logic blkReady
);
  import esn_pkg::*;

  // ************
  // input sync
  // ************
  // pins idle low, so a zero reset value gives no false edge after reset
  logic [1:0] rdySync_reg, rdySync_next;
  logic [1:0] brSync_reg, brSync_next;
  logic rdyOld_reg, rdyOld_next;
  logic brOld_reg, brOld_next;

  // only the second stage feeds logic, the first may still be settling
  always_comb begin
    rdySync_next = {rdySync_reg[0], devReady};
    brSync_next = {brSync_reg[0], busReset};
    rdyOld_next = rdySync_reg[1];
    brOld_next = brSync_reg[1];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdySync_reg <= 2'b00;
      brSync_reg <= 2'b00;
      rdyOld_reg <= 1'b0;
      brOld_reg <= 1'b0;
    end else begin
      rdySync_reg <= rdySync_next;
      brSync_reg <= brSync_next;
      rdyOld_reg <= rdyOld_next;
      brOld_reg <= brOld_next;
    end
  end

  // ************
  // edge detect
  // ************
  logic rdyRise, rdyFall, brRise;

  always_comb begin
    rdyRise = rdySync_reg[1] & ~rdyOld_reg;
    rdyFall = ~rdySync_reg[1] & rdyOld_reg;
    // bus reset notice on the rising edge only
    brRise = brSync_reg[1] & ~brOld_reg;
  end

  // ************
  // config rom
  // ************
  // command set entry
  localparam logic [31:0] ROM_CMD_SET = {`ESN_KEY_CMD_SET, CMD_SET};
  localparam logic [31:0] ROM_CMD_REV = {`ESN_KEY_CMD_REV, CMD_SET_REV};
  localparam logic [31:0] ROM_LUN = {`ESN_KEY_LUN, `ESN_DEV_TYPE_DISK, `ESN_LUN_SINGLE};
  // spec word carries its value in the top byte, the rest stays zero
  localparam logic [31:0] ROM_SPEC = {CMD_SET_SPEC, 24'h000000};
  logic [31:0] romWord_next;
  logic mediaAccessOk_next;
  logic [7:0] serialVpdPage_next;

  // securityLocked is taken as already synchronous to clk_sys
  always_comb begin
    case (romIdx)
      2'h0: romWord_next = ROM_CMD_SET;
      2'h1: romWord_next = ROM_CMD_REV;
      2'h2: romWord_next = ROM_LUN;
      default: romWord_next = ROM_SPEC;
    endcase
    // media gated by the security state
    mediaAccessOk_next = ~securityLocked;
    // serial number page for the master password
    serialVpdPage_next = `ESN_VPD_SERIAL_PAGE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      romWord <= 32'h00000000;
      mediaAccessOk <= 1'b0;
      serialVpdPage <= 8'h00;
    end else begin
      romWord <= romWord_next;
      mediaAccessOk <= mediaAccessOk_next;
      serialVpdPage <= serialVpdPage_next;
    end
  end

  // ************
  // event capture
  // ************
  logic enabled_reg, enabled_next;
  logic [47:0] fifoAddr_reg, fifoAddr_next;
  esn_event_t pwr_reg, pwr_next, med_reg, med_next, bsy_reg, bsy_next;
  esn_block_t dfr_reg, dfr_next;

  // latest data wins when one class repeats before its block goes out
  always_comb begin
    pwr_next = powerEvValid ? powerEv : pwr_reg;
    med_next = mediaEvValid ? mediaEv : med_reg;
    bsy_next = busyEvValid ? busyEv : bsy_reg;
    // deferred errors ride the same path
    dfr_next = deferredValid ? deferredBlk : dfr_reg;
    // reporting opens on the enable write; only reset closes it again
    enabled_next = enabled_reg | statusEnableWrite;
    fifoAddr_next = loginValid ? loginFifoAddr : fifoAddr_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enabled_reg <= 1'b0;
      fifoAddr_reg <= 48'h000000000000;
      pwr_reg <= '0;
      med_reg <= '0;
      bsy_reg <= '0;
      dfr_reg <= '0;
    end else begin
      enabled_reg <= enabled_next;
      fifoAddr_reg <= fifoAddr_next;
      pwr_reg <= pwr_next;
      med_reg <= med_next;
      bsy_reg <= bsy_next;
      dfr_reg <= dfr_next;
    end
  end

  // ************
  // pending flags
  // ************
  // sticky flags: a new event in the same cycle as its send wins over the clear
  // an event seen before the enable write waits here; a repeat of its class merges into one notice with the latest data
  logic [6:0] pend_reg, pend_next;
  logic [6:0] setVec, clrVec;

  always_comb begin
    // bit 0 reset, 1 not ready, 2 ready, 3 power, 4 media, 5 busy, 6 deferred
    setVec = {deferredValid, busyEvValid, mediaEvValid, powerEvValid, rdyRise, rdyFall, brRise};
    pend_next = (pend_reg & ~clrVec) | setVec;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // power on raises reset and not-ready notices
      pend_reg <= 7'h03;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ************
  // block builder
  // ************
  // two gap cycles after each accept keep consecutive blocks apart on the link
  // fifo address is copied at build time, so a later login moves only later blocks
  esn_state_t state_reg, state_next;
  esn_block_t blk_reg, blk_next;
  logic blkValid_reg, blkValid_next;
  logic [2:0] pick;

  always_comb begin
    // lowest pending bit wins: reset first, deferred errors last
    pick = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = 3'(i);
      end
    end
    clrVec = 7'h00;
    state_next = state_reg;
    blk_next = blk_reg;
    blkValid_next = blkValid_reg;
    case (state_reg)
      ESN_IDLE: begin
        // no poll command is decoded, every event is pushed out unasked
        // once enabled, send as soon as an event is pending
        if (enabled_reg && (pend_reg != 7'h00)) begin
          clrVec[pick] = 1'b1;
          blk_next.fifoAddr = fifoAddr_reg;
          blk_next.status = `ESN_STAT_CHECK;
          blk_next.senseKey = `ESN_SK_UNIT_ATTN;
          blk_next.senseQual = `ESN_SQ_NONE;
          blk_next.info = 32'h00000000;
          case (pick)
            3'd0: blk_next.senseCode = `ESN_SC_RESET;
            // not ready on the falling transition and after power on reset
            3'd1: begin
              blk_next.senseKey = `ESN_SK_NOT_READY;
              blk_next.senseCode = `ESN_SC_NOT_READY;
            end
            3'd2: blk_next.senseCode = `ESN_SC_MEDIUM_CHG;
            3'd3: begin
              blk_next.senseCode = `ESN_SC_EVENT;
              blk_next.senseQual = `ESN_SQ_POWER;
              blk_next.info = {pwr_reg.evCode, pwr_reg.evStatus, `ESN_RESERVED_BYTE, `ESN_RESERVED_BYTE};
            end
            3'd4: begin
              blk_next.senseCode = `ESN_SC_EVENT;
              blk_next.senseQual = `ESN_SQ_MEDIA;
              blk_next.info = {med_reg.evCode, med_reg.evStatus, med_reg.evSpecific};
            end
            3'd5: begin
              blk_next.senseCode = `ESN_SC_EVENT;
              blk_next.senseQual = `ESN_SQ_BUSY;
              blk_next.info = {bsy_reg.evCode, bsy_reg.evStatus, bsy_reg.evSpecific};
            end
            default: blk_next = '{status: dfr_reg.status, senseKey: dfr_reg.senseKey,
                                  senseCode: dfr_reg.senseCode, senseQual: dfr_reg.senseQual,
                                  info: dfr_reg.info, fifoAddr: fifoAddr_reg};
          endcase
          blkValid_next = 1'b1;
          state_next = ESN_SEND;
        end
      end
      ESN_SEND: begin
        if (blkReady) begin
          blkValid_next = 1'b0;
          state_next = ESN_WAIT;
        end
      end
      ESN_WAIT: state_next = ESN_IDLE;
      default: state_next = ESN_IDLE;
    endcase
  end

  // blkOut and blkValid come straight from these registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ESN_IDLE;
      blk_reg <= '0;
      blkValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      blk_reg <= blk_next;
      blkValid_reg <= blkValid_next;
    end
  end

  assign blkValid = blkValid_reg;
  assign blkOut = blk_reg;
endmodule : esn_notifier
`default_nettype wire

// File: bench/esn_props.sv
// checker of the event status notifier ports
// assumes the bind below, one clock domain
`default_nettype none
module esn_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic statusEnableWrite,
  input wire logic loginValid,
  input wire logic [47:0] loginFifoAddr,
  input wire logic securityLocked,
  input wire logic mediaAccessOk,
  input wire logic blkValid,
  input wire esn_pkg::esn_block_t blkOut,
  input wire logic blkReady
);
  import esn_pkg::*;
  logic en_reg;
  logic [47:0] addr_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_reg <= 1'b0;
    else if (statusEnableWrite) en_reg <= 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (loginValid) addr_reg <= loginFifoAddr;
  end
  // ********
  // properties
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_stand; blkValid && !blkReady |=> blkValid && $stable(blkOut); endproperty
  a_stand: assert property (p_stand) else $error("block moved while waiting");
  property p_drop; blkValid && blkReady |=> !blkValid [*2]; endproperty
  a_drop: assert property (p_drop) else $error("no gap after accept");
  property p_en; blkValid |-> en_reg; endproperty
  a_en: assert property (p_en) else $error("block before enable");
  property p_fifo; blkValid |-> blkOut.fifoAddr == addr_reg; endproperty
  a_fifo: assert property (p_fifo) else $error("wrong fifo address");
  property p_evt; blkValid && blkOut.senseCode == 8'h7F |-> blkOut.status == 8'h02 && blkOut.senseKey == 8'h06;
  endproperty
  a_evt: assert property (p_evt) else $error("bad event status or key");
  property p_qual; blkValid && blkOut.senseCode == 8'h7F |-> blkOut.senseQual inside {8'h02, 8'h04, 8'h06};
  endproperty
  a_qual: assert property (p_qual) else $error("bad event qualifier");
  property p_pow; blkValid && blkOut.senseCode == 8'h7F && blkOut.senseQual == 8'h02 |-> blkOut.info[15:0] == 16'h0;
  endproperty
  a_pow: assert property (p_pow) else $error("power bytes not reserved");
  property p_sec; $past(rst_n) |-> mediaAccessOk == !$past(securityLocked); endproperty
  a_sec: assert property (p_sec) else $error("media access wrong");
  c_acc: cover property (blkValid && blkReady);
  c_wait: cover property (blkValid && !blkReady ##1 blkReady);
  c_evt: cover property (blkValid && blkOut.senseCode == 8'h7F);
endmodule : esn_props
bind esn_notifier esn_props u_props (.*);
`default_nettype wire

// File: bench/esn_host.sv
// initiator model: takes status blocks after a chosen lag
// assumes blkValid holds until blkReady is seen high
`default_nettype none
module esn_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] lag,
  input wire logic blkValid,
  output logic blkReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  // ********
  // status fifo acceptor
  // ********
  // fifo write taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      blkReady <= 1'b0;
    end else if (blkReady) begin
      blkReady <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (blkValid) begin
      cnt_reg <= cnt_reg + 2'h1;
      blkReady <= (cnt_reg == lag);
    end
  end
endmodule : esn_host
`default_nettype wire

// File: bench/esn_notifier_tb.sv
// testbench of the event status notifier
// assumes esn_host as initiator and the bound checker
`default_nettype none
module esn_notifier_tb import esn_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, statusEnableWrite = 1'b0, loginValid = 1'b0;
  logic devReady = 1'b0, busReset = 1'b0, securityLocked = 1'b1, deferredValid = 1'b0;
  logic [1:0] romIdx = 2'h0, lag = 2'h0;
  logic [2:0] evValid = 3'h0;
  logic [31:0] romWord, lfsr = 32'h4E66;
  logic [47:0] loginFifoAddr = 48'hA5C3_0000_1F00;
  logic [7:0] serialVpdPage;
  logic mediaAccessOk, blkValid, blkReady;
  esn_event_t ev = '0;
  esn_block_t deferredBlk = '0, blkOut, q[$];
  int err_count = 0, n_compared = 0, cycles = 0;
  always #4 clk_sys = ~clk_sys;
  esn_notifier dut (.*, .powerEvValid(evValid[0]), .powerEv(ev), .mediaEvValid(evValid[1]), .mediaEv(ev),
    .busyEvValid(evValid[2]), .busyEv(ev));
  esn_host host (.*);
  // ********
  // helpers
  // ********
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input logic [111:0] seen, input logic [111:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic note(input logic [7:0] k, input logic [7:0] c, input logic [7:0] ql, input logic [31:0] inf);
    q.push_back({8'h02, k, c, ql, inf, loginFifoAddr});
  endtask : note
  task automatic drain();
    repeat (300) @(posedge clk_sys) if (q.size() == 0) break;
    repeat (4) @(posedge clk_sys);
  endtask : drain
  task automatic pulse(input int k, input logic [31:0] d);
    ev <= d;
    evValid[k] <= 1'b1;
    @(posedge clk_sys);
    evValid[k] <= 1'b0;
  endtask : pulse
  // queue empty at a block counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
    if (rst_n && blkValid === 1'b1 && blkReady === 1'b1) begin
      if (q.size() == 0) check(blkOut, '1);
      else check(blkOut, q.pop_front());
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    loginValid <= 1'b1;
    @(posedge clk_sys);
    loginValid <= 1'b0;
    securityLocked <= 1'b0;
    pulse(0, 32'h0102BEEF);
    @(negedge clk_sys);
    check(mediaAccessOk, 1'b1);
    check(serialVpdPage, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      romIdx <= i[1:0];
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(romWord, i == 0 ? 32'h3A000000 : i == 1 ? 32'h3B000000 : i == 2 ? 32'h14000000 : 32'h0);
    end
    @(posedge clk_sys);
    lag <= 2'h3;
    note(8'h06, 8'h29, 8'h00, 32'h0);
    note(8'h02, 8'h04, 8'h00, 32'h0);
    note(8'h06, 8'h7F, 8'h02, 32'h01020000);
    statusEnableWrite <= 1'b1;
    @(posedge clk_sys);
    statusEnableWrite <= 1'b0;
    drain();
    devReady <= 1'b1;
    note(8'h06, 8'h28, 8'h00, 32'h0);
    drain();
    devReady <= 1'b0;
    note(8'h02, 8'h04, 8'h00, 32'h0);
    drain();
    busReset <= 1'b1;
    note(8'h06, 8'h29, 8'h00, 32'h0);
    drain();
    busReset <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      lag <= lfsr[5:4];
      note(8'h06, 8'h7F, 8'(2 * (i % 3) + 2), (i % 3 == 0) ? {lfsr[31:16], 16'h0} : lfsr);
      pulse(i % 3, lfsr);
      drain();
    end
    lfsr = nxt(lfsr);
    deferredBlk <= {8'h02, 8'h03, 8'h11, 8'h00, lfsr, 48'h0};
    deferredValid <= 1'b1;
    q.push_back({8'h02, 8'h03, 8'h11, 8'h00, lfsr, loginFifoAddr});
    @(posedge clk_sys);
    deferredValid <= 1'b0;
    drain();
    summarize();
  end
endmodule : esn_notifier_tb
`default_nettype wire
